// [spcp_ee_model.sv]
`timescale 1ns/1ps
// ****************************************
// serial memory model
// ****************************************
module spcp_ee_model (
    input  wire logic        aclk,
    input  wire logic        ee_req,
    input  wire logic [7:0]  ee_addr,
    input  wire logic [3:0]  ee_delay,
    output logic             ee_ack,
    output logic [15:0]      ee_data
);
    logic [15:0] mem [0:255];
    logic [3:0]  wait_cnt = 4'h0;
    initial ee_ack = 1'b0;
    initial ee_data = 16'h0000;
    // answer after a varying wait; data toggles whenever no word is offered
    always @(posedge aclk) begin
        if (ee_req && !ee_ack && wait_cnt >= ee_delay) begin
            ee_ack  <= 1'b1;
            ee_data <= mem[ee_addr];
        end else begin
            ee_ack  <= 1'b0;
            ee_data <= ~ee_data;
        end
        wait_cnt <= (ee_req && !ee_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
endmodule // spcp_ee_model

// [spcp_loader.sv]
`timescale 1ns/1ps
module spcp_loader #(
    parameter int NUM_PORTS = 4
) (
    input  wire logic                                aclk,
    input  wire logic                                aresetn,
    input  wire logic [12:0]                         s_axi_awaddr,
    input  wire logic                                s_axi_awvalid,
    output logic                                     s_axi_awready,
    input  wire logic [31:0]                         s_axi_wdata,
    input  wire logic [3:0]                          s_axi_wstrb,
    input  wire logic                                s_axi_wvalid,
    output logic                                     s_axi_wready,
    output logic [1:0]                               s_axi_bresp,
    output logic                                     s_axi_bvalid,
    input  wire logic                                s_axi_bready,
    input  wire logic [12:0]                         s_axi_araddr,
    input  wire logic                                s_axi_arvalid,
    output logic                                     s_axi_arready,
    output logic [31:0]                              s_axi_rdata,
    output logic [1:0]                               s_axi_rresp,
    output logic                                     s_axi_rvalid,
    input  wire logic                                s_axi_rready,
    output logic                                     ee_req,
    output logic [7:0]                               ee_addr,
    input  wire logic                                ee_ack,
    input  wire logic [15:0]                         ee_data,
    output spcp_pkg::spcp_port_s [NUM_PORTS-1:0]     cfg_port,
    output logic                                     load_done
);

    // the word map is fixed to four ports
    if (NUM_PORTS != 4) begin : g_bad_ports
        $error("spcp_loader serves exactly four ports");
    end

    // ****************************************
    // loader sequencer
    // ****************************************
    spcp_pkg::spcp_state_e                  st_reg, st_next;
    logic [3:0]                             step_reg, step_next;
    logic                                   ee_req_next;
    logic [7:0]                             ee_addr_next;
    logic                                   done_next;
    spcp_pkg::spcp_port_s [NUM_PORTS-1:0]   port_next;
    logic                                   reload;
    logic [1:0]                             cur_port;
    logic [7:0]                             kind_base;

    assign cur_port = step_reg[1:0];

    // word kind base address: slot, power budget, PM control
    always_comb begin
        unique case (step_reg[3:2])
            2'h0:    kind_base = spcp_pkg::EE_SLOT_BASE;
            2'h1:    kind_base = spcp_pkg::EE_PWR_BASE;
            default: kind_base = spcp_pkg::EE_PMC_BASE;
        endcase
    end

    // fetch one word per step, split it into the port's fields
    always_comb begin
        st_next      = st_reg;
        step_next    = step_reg;
        ee_req_next  = ee_req;
        ee_addr_next = ee_addr;
        port_next    = cfg_port;
        unique case (st_reg)
            spcp_pkg::ST_LOAD: begin
                if (!ee_req) begin
                    ee_req_next  = 1'b1;
                    ee_addr_next = kind_base + {5'h00, cur_port, 1'b0};
                end else if (ee_ack) begin
                    ee_req_next = 1'b0;
                    unique case (step_reg[3:2])
                        2'h0: begin
                            port_next[cur_port].slot_impl = ee_data[spcp_pkg::S_SLOT];
                            port_next[cur_port].ref_clk   = ee_data[spcp_pkg::S_CLK];
                            port_next[cur_port].dsi_req   = ee_data[spcp_pkg::S_DSI];
                            port_next[cur_port].lpvc_vc1  = ee_data[spcp_pkg::S_LPVC];
                            port_next[cur_port].port_num  = ee_data[spcp_pkg::S_PNUM +: 3];
                            port_next[cur_port].tc_map    = ee_data[spcp_pkg::S_TCM +: 7];
                        end
                        2'h1: begin
                            port_next[cur_port].base_power = ee_data[spcp_pkg::S_BASE +: 8];
                            port_next[cur_port].data_scale = ee_data[spcp_pkg::S_SCL +: 2];
                            port_next[cur_port].pm_state   = ee_data[spcp_pkg::S_PMS +: 2];
                            port_next[cur_port].sys_alloc  = ee_data[spcp_pkg::S_SYSA];
                        end
                        default: begin
                            port_next[cur_port].pm_ctl     = ee_data[spcp_pkg::S_PMC +: 6];
                            port_next[cur_port].rx_pol_dis = ee_data[spcp_pkg::S_RXP];
                            port_next[cur_port].vga_en     = ee_data[spcp_pkg::S_VGA];
                            port_next[cur_port].phy_vendor_control_5 =
                                ee_data[spcp_pkg::S_PHY +: 8];
                        end
                    endcase
                    if (step_reg == spcp_pkg::LAST_STEP) begin
                        st_next = spcp_pkg::ST_DONE;
                    end else begin
                        step_next = step_reg + 4'h1;
                    end
                end
            end
            spcp_pkg::ST_DONE: begin
                if (reload) begin
                    st_next   = spcp_pkg::ST_LOAD;
                    step_next = 4'h0;
                end
            end
        endcase
        done_next = (st_next == spcp_pkg::ST_DONE);
    end

    // sequencer registers; fields reset to their hardware defaults (zero)
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg    <= spcp_pkg::ST_LOAD;
            step_reg  <= 4'h0;
            ee_req    <= 1'b0;
            ee_addr   <= 8'h00;
            cfg_port  <= '0;
            load_done <= 1'b0;
        end else begin
            st_reg    <= st_next;
            step_reg  <= step_next;
            ee_req    <= ee_req_next;
            ee_addr   <= ee_addr_next;
            cfg_port  <= port_next;
            load_done <= done_next;
        end
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic        aw_full_reg, aw_full_next;
    logic        w_full_reg, w_full_next;
    logic [12:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic        wbit0_ok;
    logic        awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
    logic [1:0]  bresp_next, rresp_next;
    logic [31:0] rdata_next;

    assign wbit0_ok = s_axi_wstrb[0];

    // true when the offset holds loaded fields
    function automatic logic off_mapped(input logic [9:0] off);
        unique case (off)
            spcp_pkg::OFF_DSI, spcp_pkg::OFF_VGA, spcp_pkg::OFF_PMC, spcp_pkg::OFF_PHY,
            spcp_pkg::OFF_SLOT, spcp_pkg::OFF_PNUM, spcp_pkg::OFF_CLK, spcp_pkg::OFF_LPVC,
            spcp_pkg::OFF_TCMAP, spcp_pkg::OFF_PWR, spcp_pkg::OFF_SYSA: off_mapped = 1'b1;
            default: off_mapped = 1'b0;
        endcase
    endfunction

    // write path: address and data taken in either order, answered together
    always_comb begin
        aw_full_next = aw_full_reg;
        w_full_next  = w_full_reg;
        awaddr_next  = awaddr_reg;
        wdata_next   = wdata_reg;
        bvalid_next  = s_axi_bvalid;
        bresp_next   = s_axi_bresp;
        reload       = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_next = 1'b1;
            awaddr_next  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_next = 1'b1;
            wdata_next  = {s_axi_wdata[31:1], s_axi_wdata[0] & wbit0_ok};
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (aw_full_reg && w_full_reg && !s_axi_bvalid) begin
            aw_full_next = 1'b0;
            w_full_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = spcp_pkg::RESP_DECERR;
            if (awaddr_reg[12:10] == spcp_pkg::PAGE_LDR) begin
                if (awaddr_reg[9:0] == spcp_pkg::OFF_LDR_CTRL) begin
                    bresp_next = spcp_pkg::RESP_OKAY;
                    reload     = wdata_reg[0];
                end else if (awaddr_reg[9:0] == spcp_pkg::OFF_LDR_STAT) begin
                    bresp_next = spcp_pkg::RESP_OKAY;
                end
            end else if (!awaddr_reg[12] && off_mapped(awaddr_reg[9:0])) begin
                bresp_next = spcp_pkg::RESP_OKAY;  // loaded fields are read-only
            end
        end
        // no access is taken until every field is loaded
        awready_next = !aw_full_next && !bvalid_next && done_next;
        wready_next  = !w_full_next && !bvalid_next && done_next;
    end

    // read path: one read at a time, answered the cycle after it is taken
    always_comb begin
        spcp_pkg::spcp_port_s p;
        logic [9:0]           off;
        p           = cfg_port[s_axi_araddr[11:10]];
        off         = s_axi_araddr[9:0];
        rvalid_next = s_axi_rvalid;
        rdata_next  = s_axi_rdata;
        rresp_next  = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rdata_next  = 32'h0000_0000;
            rresp_next  = spcp_pkg::RESP_OKAY;
            if (!s_axi_araddr[12]) begin
                unique case (off)
                    spcp_pkg::OFF_SLOT:  rdata_next[spcp_pkg::B_SLOT] = p.slot_impl;
                    spcp_pkg::OFF_CLK:   rdata_next[spcp_pkg::B_CLK]  = p.ref_clk;
                    spcp_pkg::OFF_DSI:   rdata_next[spcp_pkg::B_DSI]  = p.dsi_req;
                    spcp_pkg::OFF_LPVC:  rdata_next[spcp_pkg::B_LPVC] = p.lpvc_vc1;
                    spcp_pkg::OFF_PNUM:  rdata_next[spcp_pkg::B_PNUM +: 3] = p.port_num;
                    spcp_pkg::OFF_TCMAP: rdata_next[spcp_pkg::B_TCM +: 7]  = p.tc_map;
                    spcp_pkg::OFF_PWR: begin
                        rdata_next[spcp_pkg::B_BASE +: 8] = p.base_power;
                        rdata_next[spcp_pkg::B_SCL +: 2]  = p.data_scale;
                        rdata_next[spcp_pkg::B_PMS +: 2]  = p.pm_state;
                    end
                    spcp_pkg::OFF_SYSA:  rdata_next[spcp_pkg::B_SYSA] = p.sys_alloc;
                    spcp_pkg::OFF_PMC: begin
                        rdata_next[spcp_pkg::B_PMC +: 6] = p.pm_ctl;
                        rdata_next[spcp_pkg::B_RXP]      = p.rx_pol_dis;
                    end
                    spcp_pkg::OFF_VGA:   rdata_next[spcp_pkg::B_VGA] = p.vga_en;
                    spcp_pkg::OFF_PHY:   rdata_next[spcp_pkg::B_PHY +: 8] = p.phy_vendor_control_5;
                    default:             rresp_next = spcp_pkg::RESP_DECERR;
                endcase
            end else if (s_axi_araddr[12:10] == spcp_pkg::PAGE_LDR &&
                         off == spcp_pkg::OFF_LDR_STAT) begin
                rdata_next[7:0] = {step_reg, 2'h0, !load_done, load_done};
            end else if (!(s_axi_araddr[12:10] == spcp_pkg::PAGE_LDR &&
                           off == spcp_pkg::OFF_LDR_CTRL)) begin
                rresp_next = spcp_pkg::RESP_DECERR;
            end
        end
        arready_next = !rvalid_next && done_next;
    end

    // bus registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg   <= 1'b0;
            w_full_reg    <= 1'b0;
            awaddr_reg    <= 13'h0000;
            wdata_reg     <= 32'h0000_0000;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else begin
            aw_full_reg   <= aw_full_next;
            w_full_reg    <= w_full_next;
            awaddr_reg    <= awaddr_next;
            wdata_reg     <= wdata_next;
            s_axi_awready <= awready_next;
            s_axi_wready  <= wready_next;
            s_axi_bvalid  <= bvalid_next;
            s_axi_bresp   <= bresp_next;
            s_axi_arready <= arready_next;
            s_axi_rvalid  <= rvalid_next;
            s_axi_rdata   <= rdata_next;
            s_axi_rresp   <= rresp_next;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_take(logic [1:0] k);
        ee_req && ee_ack && step_reg[3:2] == k;
    endsequence

    a_slot_impl: assert property (s_take(2'h0) |=>
        cfg_port[$past(cur_port)].slot_impl == $past(ee_data[0]))
        else $error("slot implemented bit not loaded");
    a_port_num: assert property (s_take(2'h0) |=>
        cfg_port[$past(cur_port)].port_num == $past(ee_data[6:4]))
        else $error("port number field not loaded");
    a_tc_map: assert property (s_take(2'h0) |=>
        cfg_port[$past(cur_port)].tc_map == $past(ee_data[15:9]))
        else $error("tc map field not loaded");
    a_port3_addr: assert property (ee_req && step_reg == 4'h3 |->
        ee_addr == spcp_pkg::EE_SLOT_BASE + 8'h06)
        else $error("port 3 slot word fetched from wrong address");
    a_base_power: assert property (s_take(2'h1) |=>
        cfg_port[$past(cur_port)].base_power == $past(ee_data[7:0]))
        else $error("base power not loaded");
    a_pm_state: assert property (s_take(2'h1) |=>
        cfg_port[$past(cur_port)].pm_state == $past(ee_data[11:10]))
        else $error("pm state not loaded");
    a_sys_alloc: assert property (s_take(2'h1) |=>
        cfg_port[$past(cur_port)].sys_alloc == $past(ee_data[15]))
        else $error("system allocated flag not loaded");
    a_pm_ctl: assert property (s_take(2'h2) |=>
        cfg_port[$past(cur_port)].pm_ctl == $past(ee_data[5:0]))
        else $error("pm control bits not loaded");
    a_phy_ctl: assert property (s_take(2'h2) |=>
        cfg_port[$past(cur_port)].phy_vendor_control_5 == $past(ee_data[15:8]))
        else $error("phy control byte not loaded");
    a_hold_off: assert property (!load_done |->
        !s_axi_arready && !s_axi_awready && !s_axi_wready)
        else $error("bus accepted an access before load finished");

endmodule // spcp_loader

// [spcp_pkg.sv]
package spcp_pkg;

    // ****************************************
    // serial memory word addresses
    // ****************************************
    localparam logic [7:0] EE_SLOT_BASE = 8'h60;  // slot word, port 0; +2 per port
    localparam logic [7:0] EE_PWR_BASE  = 8'h70;  // power budget word, port 0
    localparam logic [7:0] EE_PMC_BASE  = 8'h80;  // power-management control word, port 0
    localparam logic [3:0] LAST_STEP    = 4'hB;   // three word kinds times four ports

    // ****************************************
    // configuration offsets inside one port page
    // ****************************************
    localparam logic [9:0] OFF_DSI   = 10'h040;
    localparam logic [9:0] OFF_VGA   = 10'h070;
    localparam logic [9:0] OFF_PMC   = 10'h074;
    localparam logic [9:0] OFF_PHY   = 10'h088;
    localparam logic [9:0] OFF_SLOT  = 10'h0C0;
    localparam logic [9:0] OFF_PNUM  = 10'h0CC;
    localparam logic [9:0] OFF_CLK   = 10'h0D0;
    localparam logic [9:0] OFF_LPVC  = 10'h144;
    localparam logic [9:0] OFF_TCMAP = 10'h154;
    localparam logic [9:0] OFF_PWR   = 10'h214;
    localparam logic [9:0] OFF_SYSA  = 10'h218;

    // loader page: control and status
    localparam logic [2:0] PAGE_LDR      = 3'h4;
    localparam logic [9:0] OFF_LDR_CTRL  = 10'h000;
    localparam logic [9:0] OFF_LDR_STAT  = 10'h004;

    // ****************************************
    // field positions: source word (S_) and register (B_)
    // ****************************************
    localparam int S_SLOT = 0,  B_SLOT  = 24;
    localparam int S_CLK  = 1,  B_CLK   = 28;
    localparam int S_DSI  = 2,  B_DSI   = 21;
    localparam int S_LPVC = 3,  B_LPVC  = 4;
    localparam int S_PNUM = 4,  B_PNUM  = 24;
    localparam int S_TCM  = 9,  B_TCM   = 1;
    localparam int S_BASE = 0,  B_BASE  = 0;
    localparam int S_SCL  = 8,  B_SCL   = 8;
    localparam int S_PMS  = 10, B_PMS   = 13;
    localparam int S_SYSA = 15, B_SYSA  = 0;
    localparam int S_PMC  = 0,  B_PMC   = 8;
    localparam int S_RXP  = 6,  B_RXP   = 14;
    localparam int S_VGA  = 7,  B_VGA   = 31;
    localparam int S_PHY  = 8,  B_PHY   = 24;

    // ****************************************
    // responses, states, carriers
    // ****************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [0:0] {ST_LOAD = 1'b0, ST_DONE = 1'b1} spcp_state_e;

    typedef struct packed {
        logic       slot_impl;
        logic       ref_clk;
        logic       dsi_req;
        logic       lpvc_vc1;
        logic [2:0] port_num;
        logic [6:0] tc_map;
        logic [7:0] base_power;
        logic [1:0] data_scale;
        logic [1:0] pm_state;
        logic       sys_alloc;
        logic [5:0] pm_ctl;
        logic       rx_pol_dis;
        logic       vga_en;
        logic [7:0] phy_vendor_control_5;
    } spcp_port_s;

endpackage

// [test_spcp_loader.sv]
`timescale 1ns/1ps
module test_spcp_loader;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [12:0] s_axi_awaddr = 13'h0000, s_axi_araddr = 13'h0000;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0, ee_delay = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic ee_req, ee_ack, load_done;
    logic [7:0]  ee_addr;
    logic [15:0] ee_data;
    spcp_pkg::spcp_port_s [3:0] cfg_port;
    logic [15:0] words [12];
    logic [9:0]  offs [11] = '{10'h040, 10'h070, 10'h074, 10'h088, 10'h0C0, 10'h0CC,
                               10'h0D0, 10'h144, 10'h154, 10'h214, 10'h218};
    logic [31:0] seed = 32'h5BD7538E, d;
    logic [1:0]  r;
    int fail_count = 0, n_compared = 0, cycles = 0;

    spcp_loader i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ee_req, .ee_addr, .ee_ack, .ee_data,
        .cfg_port, .load_done);
    spcp_ee_model i_mem (.aclk, .ee_req, .ee_addr, .ee_delay, .ee_ack, .ee_data);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // expected register readback from the loaded words
    function automatic logic [31:0] exp_reg(input int p, input logic [9:0] o);
        logic [15:0] s, w, m;
        s = words[p];
        w = words[p + 4];
        m = words[p + 8];
        case (o)
            10'h0C0: return 32'(s[0]) << 24;
            10'h0D0: return 32'(s[1]) << 28;
            10'h040: return 32'(s[2]) << 21;
            10'h144: return 32'(s[3]) << 4;
            10'h0CC: return 32'(s[6:4]) << 24;
            10'h154: return 32'(s[15:9]) << 1;
            10'h214: return 32'({w[11:10], 3'h0, w[9:0]});
            10'h218: return 32'(w[15]);
            10'h074: return 32'(m[6:0]) << 8;
            10'h070: return 32'(m[7]) << 31;
            default: return 32'(m[15:8]) << 24;
        endcase
    endfunction

    task automatic check(input string name, input logic [63:0] e, input logic [63:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic axi_rd(input logic [12:0] a, output logic [31:0] dd, output logic [1:0] rr);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        dd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic axi_wr(input logic [12:0] a, input logic [31:0] dd, input logic [3:0] st,
                          output logic [1:0] rr);
        bit aw = 0, wd = 0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, dd, st};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) aw = 1;
            if (s_axi_wvalid && s_axi_wready) wd = 1;
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !wd;
        end while (!(aw && wd));
        do @(posedge aclk); while (!s_axi_bvalid);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // new memory contents, optionally with boundary words
    task automatic fill(input bit corner);
        for (int i = 0; i < 12; i++) begin
            words[i] = (corner && i == 8) ? 16'hFFFF : (corner && i == 6) ? 16'h8000 : 16'(rnd());
            i_mem.mem[8'h60 + 8'(i / 4 * 16 + i % 4 * 2)] = words[i];
        end
    endtask

    task automatic wait_load();
        int n = 0;
        do begin @(posedge aclk); n++; end while (load_done !== 1'b0 && n < 20);
        check("load_done low", 0, load_done);
        while (load_done !== 1'b1) begin
            check("readies during load", 0, {s_axi_arready, s_axi_awready, s_axi_wready});
            @(posedge aclk);
        end
    endtask

    task automatic check_all();
        logic [15:0] s, w, m;
        for (int p = 0; p < 4; p++) begin
            {s, w, m} = {words[p], words[p + 4], words[p + 8]};
            check("cfg_port", {s[0], s[1], s[2], s[3], s[6:4], s[15:9], w[7:0], w[9:8],
                w[11:10], w[15], m[5:0], m[6], m[7], m[15:8]}, cfg_port[p]);
            for (int k = 0; k < 11; k++) begin
                axi_rd({3'(p), offs[k]}, d, r);
                check("port register", exp_reg(p, offs[k]), d);
                check("read resp", 0, r);
            end
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ****************************************
    // clock, memory pace and timeout
    // ****************************************
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        ee_delay <= 4'(rnd() % 6);
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        fill(1);
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        wait_load();
        check_all();
        axi_rd(13'h1004, d, r);
        check("status", {24'h0, spcp_pkg::LAST_STEP, 4'h1}, d);
        axi_rd(13'h1000, d, r);
        check("control read", 0, {r, d});
        axi_wr({3'h2, 10'h214}, 32'hFFFFFFFF, 4'hF, r);
        check("read-only write resp", 0, r);
        axi_wr(13'h1400, 32'h0, 4'hF, r);
        check("unmapped write resp", 3, r);
        axi_wr(13'h03FC, 32'h0, 4'hF, r);
        check("unmapped offset write resp", 3, r);
        axi_rd(13'h03FC, d, r);
        check("unmapped read resp", 3, r);
        // reload request with the low byte lane masked must be ignored
        axi_wr(13'h1000, 32'h1, 4'hE, r);
        check("masked reload resp", 0, r);
        @(posedge aclk);
        check("masked reload ignored", 1, load_done);
        fill(0);
        axi_wr(13'h1000, 32'h1, 4'hF, r);
        check("reload write resp", 0, r);
        wait_load();
        check_all();
        end_of_test();
    end
endmodule // test_spcp_loader
